// File: design/rmgc_ctrl.sv
`timescale 1ns/10ps

module rmgc_ctrl (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic transmit_select_i,
	input wire logic antenna_choice_i,
	input wire logic power_down_n_i,
	input wire logic [6:0] gain_pins_i,
	input wire logic ser_cs_n_i,
	input wire logic ser_sclk_i,
	input wire logic ser_din_i,
	output rmgc_pkg::rmgc_route_t route_o,
	output rmgc_pkg::rmgc_gain_t gain_o,
	output logic [7:0] lpf_corner_o
);

	// ==========================================================
	// Pin synchronisers
	logic [12:0] pin_raw;
	logic [12:0] sync1_r;
	logic [12:0] sync2_r;

	assign pin_raw = {gain_pins_i, ser_din_i, ser_sclk_i, ser_cs_n_i,
		power_down_n_i, antenna_choice_i, transmit_select_i};

	genvar gi;
	generate
		for (gi = 0; gi < rmgc_pkg::PIN_W; gi++)
		begin : g_sync
			always_ff @(posedge mclk_i)
			begin
				if (!rstn_i)
				begin
					// Chip select lane resets high, its idle level, so no false frame end
					sync1_r[gi] <= 1'(gi == rmgc_pkg::P_CSN);
					sync2_r[gi] <= 1'(gi == rmgc_pkg::P_CSN);
				end
				else if (ce_i)
				begin
					sync1_r[gi] <= pin_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	wire tx_s = sync2_r[rmgc_pkg::P_TXSEL];
	wire ant_s = sync2_r[rmgc_pkg::P_ANTENNA_CHOICE];
	wire pdn_s = sync2_r[rmgc_pkg::P_PDN];
	wire csn_s = sync2_r[rmgc_pkg::P_CSN];
	wire sclk_s = sync2_r[rmgc_pkg::P_SCLK];
	wire din_s = sync2_r[rmgc_pkg::P_DIN];
	wire [6:0] pins_s = sync2_r[rmgc_pkg::P_GAIN +: rmgc_pkg::GAIN_PIN_W];

	// ==========================================================
	// Three-wire serial write port
	// Serial clock is oversampled; it must stay well below mclk/4.
	logic sclk_d_r;
	logic csn_d_r;
	logic [17:0] shift_r;
	logic [17:0] shift_nxt;
	logic [13:0] filter_cfg_r;
	logic [13:0] filter_cfg_nxt;
	logic [13:0] rx_gain_r;
	logic [13:0] rx_gain_nxt;

	wire sclk_rise = sclk_s & ~sclk_d_r & ~csn_s;
	wire frame_end = csn_s & ~csn_d_r;
	wire [3:0] frame_addr = shift_r[rmgc_pkg::ADDR_W-1:0];
	wire [13:0] frame_data = shift_r[rmgc_pkg::FRAME_W-1:rmgc_pkg::ADDR_W];
	wire wr_cfg = frame_end && (frame_addr == rmgc_pkg::ADDR_FILTER_CFG);
	wire wr_gain = frame_end && (frame_addr == rmgc_pkg::ADDR_RX_GAIN);

	assign shift_nxt = sclk_rise ? {shift_r[16:0], din_s} : shift_r;
	// Other addresses belong to other blocks and are dropped here
	assign filter_cfg_nxt = wr_cfg ? frame_data : filter_cfg_r;
	// Fields hold until a frame to their own address lands, whatever the source
	assign rx_gain_nxt = wr_gain ? frame_data : rx_gain_r;

	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			sclk_d_r <= 1'b0;
			csn_d_r <= 1'b1;
			shift_r <= 18'h00000;
			filter_cfg_r <= rmgc_pkg::FILTER_CFG_RST;
			rx_gain_r <= rmgc_pkg::RX_GAIN_RST;
		end
		else if (ce_i)
		begin
			sclk_d_r <= sclk_s;
			csn_d_r <= csn_s;
			shift_r <= shift_nxt;
			filter_cfg_r <= filter_cfg_nxt;
			rx_gain_r <= rx_gain_nxt;
		end
	end
	// No output carries register contents back

	// ==========================================================
	// Gain source and decode
	function automatic rmgc_pkg::rmgc_lna_t lna_decode(input logic [1:0] code);
		if (!code[1])
			lna_decode = rmgc_pkg::RMGC_LNA_LOW;
		else if (code[0])
			lna_decode = rmgc_pkg::RMGC_LNA_HIGH;
		else
			lna_decode = rmgc_pkg::RMGC_LNA_MED;
	endfunction

	wire serial_src = filter_cfg_r[rmgc_pkg::GAIN_SRC_BIT];
	wire [1:0] lna_ser = rx_gain_r[rmgc_pkg::LNA_LSB +: 2];
	wire [4:0] vga_ser = rx_gain_r[rmgc_pkg::VGA_LSB +: rmgc_pkg::VGA_W];
	wire [1:0] lna_code = serial_src ? lna_ser : pins_s[6:5];
	wire [4:0] vga_code = serial_src ? vga_ser : pins_s[4:0];
	wire rmgc_pkg::rmgc_lna_t lna_mode = lna_decode(lna_code);
	wire [5:0] lna_att = (lna_mode == rmgc_pkg::RMGC_LNA_HIGH) ? rmgc_pkg::LNA_ATT_HIGH_DB :
		(lna_mode == rmgc_pkg::RMGC_LNA_MED) ? rmgc_pkg::LNA_ATT_MED_DB :
		rmgc_pkg::LNA_ATT_LOW_DB;
	// Binary weights: code times step gives 0..62 dB above minimum
	wire [5:0] vga_db = 6'(vga_code * rmgc_pkg::VGA_STEP_DB);
	wire [1:0] lpf_sel = filter_cfg_r[rmgc_pkg::LPF_LSB +: 2];
	wire [7:0] lpf_dec = (lpf_sel == 2'b00) ? rmgc_pkg::LPF_11B :
		(lpf_sel == 2'b01) ? rmgc_pkg::LPF_11G :
		(lpf_sel == 2'b10) ? rmgc_pkg::LPF_TURBO1 : rmgc_pkg::LPF_TURBO2;

	// ==========================================================
	// Switch routing and enables
	rmgc_pkg::rmgc_route_t route_nxt;
	rmgc_pkg::rmgc_gain_t gain_nxt;
	// Break-before-make is left to the analog switch drivers
	assign route_nxt.primary_antenna_port_rx = ~tx_s & ~ant_s;
	assign route_nxt.secondary_antenna_port_rx = ~tx_s & ant_s;
	assign route_nxt.secondary_antenna_port_tx = tx_s;
	assign route_nxt.rx_en = ~tx_s & pdn_s;
	assign route_nxt.tx_en = tx_s & pdn_s;
	assign gain_nxt.lna_mode = lna_mode;
	assign gain_nxt.lna_atten_db = lna_att;
	assign gain_nxt.vga_code = vga_code;
	assign gain_nxt.vga_gain_db = vga_db;
	assign gain_nxt.serial_src = serial_src;

	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			route_o <= '0;
			gain_o <= '0;
			lpf_corner_o <= rmgc_pkg::LPF_11B;
		end
		else if (ce_i)
		begin
			route_o <= route_nxt;
			gain_o <= gain_nxt;
			lpf_corner_o <= lpf_dec;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	main_rx_path_a: assert property (ce_i && !tx_s && !ant_s |=> route_o.primary_antenna_port_rx && !route_o.secondary_antenna_port_tx)
		else $error("primary receive path not selected");
	div_rx_path_a: assert property (ce_i && !tx_s && ant_s |=> route_o.secondary_antenna_port_rx && !route_o.primary_antenna_port_rx)
		else $error("diversity receive path not selected");
	tx_path_a: assert property (ce_i && tx_s |=> route_o.secondary_antenna_port_tx && !route_o.primary_antenna_port_rx && !route_o.secondary_antenna_port_rx)
		else $error("transmit path not on secondary port");
	rx_enable_a: assert property (ce_i |=> route_o.rx_en == (!$past(tx_s) && $past(pdn_s)))
		else $error("receiver enable wrong");
	lna_levels_a: assert property (gain_o.lna_atten_db inside {6'h00, 6'h10, 6'h21})
		else $error("illegal LNA attenuation");
	lna_code_a: assert property (ce_i && lna_code == 2'b10 |=> gain_o.lna_mode == rmgc_pkg::RMGC_LNA_MED)
		else $error("LNA medium decode wrong");
	lna_serial_a: assert property (ce_i && serial_src && rx_gain_r[6:5] == 2'b11
		|=> gain_o.lna_mode == rmgc_pkg::RMGC_LNA_HIGH)
		else $error("serial LNA code not applied");
	gain_source_a: assert property (ce_i && !serial_src |=> gain_o.vga_code == $past(pins_s[4:0]))
		else $error("pin gain not applied");
	vga_weight_a: assert property (gain_o.vga_gain_db == {gain_o.vga_code, 1'b0})
		else $error("VGA weight wrong");
	vga_serial_a: assert property (ce_i && serial_src |=> gain_o.vga_code == $past(rx_gain_r[4:0]))
		else $error("serial VGA code not applied");
	lpf_turbo_a: assert property (ce_i && lpf_sel == 2'b11 |=> lpf_corner_o == 8'hB4)
		else $error("turbo 2 corner wrong");
	field_hold_a: assert property (ce_i && !wr_gain |=> $stable(rx_gain_r))
		else $error("gain field changed without write");
	ant_ignored_a: assert property (ce_i && tx_s |=> !route_o.primary_antenna_port_rx && !route_o.rx_en)
		else $error("receive path open while transmitting");
	lna_low_a: assert property (ce_i && !lna_code[1] |=> gain_o.lna_mode == rmgc_pkg::RMGC_LNA_LOW)
		else $error("LNA low decode wrong");
	lna_high_a: assert property (ce_i && lna_code == 2'b11
		|=> gain_o.lna_mode == rmgc_pkg::RMGC_LNA_HIGH)
		else $error("LNA high decode wrong");
	vga_span_a: assert property (gain_o.vga_gain_db <= 6'h3E)
		else $error("VGA gain beyond range");
	vga_max_a: assert property (ce_i && vga_code == 5'h1F |=> gain_o.vga_gain_db == 6'h3E)
		else $error("VGA all ones not maximum");
	lpf_base_a: assert property (ce_i && lpf_sel == 2'b00 |=> lpf_corner_o == rmgc_pkg::LPF_11B)
		else $error("base corner wrong");

endmodule // rmgc_ctrl

// File: design/rmgc_pkg.sv
package rmgc_pkg;

	// ==========================================================
	// Serial frame and register map
	localparam int FRAME_W = 18;
	localparam int DATA_W = 14;
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_FILTER_CFG = 4'h8;
	localparam logic [3:0] ADDR_RX_GAIN = 4'hB;
	localparam logic [13:0] FILTER_CFG_RST = 14'h0000;
	localparam logic [13:0] RX_GAIN_RST = 14'h0000;

	// ==========================================================
	// Field positions
	localparam int GAIN_SRC_BIT = 12;
	localparam int LPF_LSB = 0;
	localparam int LNA_LSB = 5;
	localparam int VGA_LSB = 0;
	localparam int VGA_W = 5;
	localparam int GAIN_PIN_W = 7;

	// ==========================================================
	// Gain figures in dB
	localparam logic [5:0] LNA_ATT_HIGH_DB = 6'h00;
	localparam logic [5:0] LNA_ATT_MED_DB = 6'h10;
	localparam logic [5:0] LNA_ATT_LOW_DB = 6'h21;
	localparam int VGA_STEP_DB = 2;

	// ==========================================================
	// Lowpass coarse corner, units of 100 kHz
	localparam logic [7:0] LPF_11B = 8'h4B;
	localparam logic [7:0] LPF_11G = 8'h55;
	localparam logic [7:0] LPF_TURBO1 = 8'h96;
	localparam logic [7:0] LPF_TURBO2 = 8'hB4;

	// ==========================================================
	// Pin synchroniser lanes
	localparam int PIN_W = 13;
	localparam int P_TXSEL = 0;
	localparam int P_ANTENNA_CHOICE = 1;
	localparam int P_PDN = 2;
	localparam int P_CSN = 3;
	localparam int P_SCLK = 4;
	localparam int P_DIN = 5;
	localparam int P_GAIN = 6;

	typedef enum logic [1:0] {
		RMGC_LNA_LOW = 2'b00,
		RMGC_LNA_MED = 2'b01,
		RMGC_LNA_HIGH = 2'b10
	} rmgc_lna_t;

	typedef struct packed {
		logic primary_antenna_port_rx;
		logic secondary_antenna_port_rx;
		logic secondary_antenna_port_tx;
		logic rx_en;
		logic tx_en;
	} rmgc_route_t;

	typedef struct packed {
		rmgc_lna_t lna_mode;
		logic [5:0] lna_atten_db;
		logic [4:0] vga_code;
		logic [5:0] vga_gain_db;
		logic serial_src;
	} rmgc_gain_t;

endpackage

// File: sim/rmgc_bb_model.sv
`timescale 1ns/10ps

// ==========================================================
// Baseband controller, serial port side
module rmgc_bb_model (
	input wire logic mclk_i,
	output logic ser_cs_n_o,
	output logic ser_sclk_o,
	output logic ser_din_o
);
	initial
	begin
		ser_cs_n_o = 1'b1;
		ser_sclk_o = 1'b0;
		ser_din_o = 1'b0;
	end

	// Five cycles a phase, one over the minimum
	task automatic hold5();
		repeat (5) @(posedge mclk_i);
		#1;
	endtask

	// Data first, then address; clock idles low
	task automatic write(input logic [3:0] addr, input logic [13:0] data);
		logic [17:0] frame;
		frame = {data, addr};
		ser_cs_n_o = 1'b0;
		for (int i = 17; i >= 0; i--)
		begin
			ser_din_o = frame[i];
			hold5();
			ser_sclk_o = 1'b1;
			hold5();
			ser_sclk_o = 1'b0;
		end
		ser_cs_n_o = 1'b1;
		// Line no longer valid, show a wrong value
		ser_din_o = ~frame[0];
		hold5();
	endtask
endmodule // rmgc_bb_model

// File: sim/test_rx_mode_and_gain_control.sv
`timescale 1ns/10ps

module test_rx_mode_and_gain_control;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ce_i = 1'b1;
	logic txs = 1'b0;
	logic ant = 1'b0;
	logic pdn = 1'b1;
	logic [6:0] pins = 7'h00;
	logic cs_n, sclk, din;
	rmgc_pkg::rmgc_route_t route_o;
	rmgc_pkg::rmgc_gain_t gain_o;
	logic [7:0] lpf;
	int num_errors = 0;
	int n_tests = 0;
	// {transmit, antenna, power_down_n, expected route}
	logic [7:0] rows [6] = '{8'h32, 8'h6A, 8'hA5, 8'hE5, 8'h10, 8'hC4};
	logic [6:0] codes [6] = '{7'h7F, 7'h5E, 7'h3F, 7'h00, 7'h41, 7'h2A};
	logic [7:0] corners [4] = '{8'h4B, 8'h55, 8'h96, 8'hB4};

	initial
	begin
		forever #2.5 mclk_i = ~mclk_i;
	end

	rmgc_ctrl dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .transmit_select_i(txs),
		.antenna_choice_i(ant), .power_down_n_i(pdn), .gain_pins_i(pins),
		.ser_cs_n_i(cs_n), .ser_sclk_i(sclk), .ser_din_i(din), .route_o(route_o),
		.gain_o(gain_o), .lpf_corner_o(lpf));
	rmgc_bb_model bb (.mclk_i(mclk_i), .ser_cs_n_o(cs_n), .ser_sclk_o(sclk), .ser_din_o(din));

	// ==========================================================
	// Helpers
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	function automatic rmgc_pkg::rmgc_gain_t eg(input logic [6:0] c, input logic s);
		rmgc_pkg::rmgc_gain_t g;
		g.lna_mode = c[6] ? (c[5] ? rmgc_pkg::RMGC_LNA_HIGH : rmgc_pkg::RMGC_LNA_MED)
			: rmgc_pkg::RMGC_LNA_LOW;
		g.lna_atten_db = c[6] ? (c[5] ? 6'h00 : 6'h10) : 6'h21;
		g.vga_code = c[4:0];
		g.vga_gain_db = {c[4:0], 1'b0};
		g.serial_src = s;
		return g;
	endfunction

	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		#400000;
		num_errors++;
		test_done();
	end

	// ==========================================================
	// Sequence
	initial
	begin
		step(5);
		check(route_o, 5'h00);
		check(gain_o, 20'h00000);
		check(lpf, 8'h4B);
		rstn_i = 1'b1;
		// Antenna high with transmit low is the diversity receive case
		for (int i = 0; i < 6; i++)
		begin
			{txs, ant, pdn} = rows[i][7:5];
			pins = codes[i];
			step(4);
			check(route_o, rows[i][4:0]);
			check(gain_o, eg(codes[i], 1'b0));
		end
		$display("pin decode done");
		ce_i = 1'b0;
		{txs, ant, pdn} = 3'b011;
		step(4);
		check(route_o, 5'h04);
		ce_i = 1'b1;
		step(4);
		check(route_o, 5'h0A);
		bb.write(4'h8, 14'h1000);
		step(8);
		check(gain_o, eg(7'h00, 1'b1));
		bb.write(4'hB, 14'h3F55);
		step(8);
		pins = 7'h7F;
		step(4);
		check(gain_o, eg(7'h55, 1'b1));
		bb.write(4'h3, 14'h3FFF);
		step(8);
		check(gain_o, eg(7'h55, 1'b1));
		check(lpf, 8'h4B);
		for (int i = 0; i < 4; i++)
		begin
			bb.write(4'h8, {12'h400, i[1:0]});
			step(8);
			check(lpf, corners[i]);
		end
		bb.write(4'h8, 14'h0000);
		step(8);
		check(gain_o, eg(7'h7F, 1'b0));
		bb.write(4'h8, 14'h1000);
		step(8);
		check(gain_o, eg(7'h55, 1'b1));
		$display("serial path done");
		rstn_i = 1'b0;
		step(2);
		check(route_o, 5'h00);
		check(gain_o, 20'h00000);
		check(lpf, 8'h4B);
		rstn_i = 1'b1;
		step(4);
		check(route_o, 5'h0A);
		check(gain_o, eg(7'h7F, 1'b0));
		$display("mid-run reset done");
		test_done();
	end
endmodule // test_rx_mode_and_gain_control
